// >>> rtl/rxdma_regs.svh
// Function
// R1 - Skip leading first-buffer bytes by skip count
// R2 - Software sets skip count 0..0xff at setup
// R3 - Queue head pointer in bits 31:2
// R4 - First descriptor pointer of current packet
// R5 - Packet-active flag set while inside packet
// R6 - Active descriptor pointer of filling buffer
// R7 - Full 32-bit next byte write address
// R8 - Count packet bytes, write to word3
// R9 - Free byte count of current buffer
// R10 - Pointer match with mode bit clear clears receive interrupt; mode bit set loads pointer and sets it
// R11 - Per byte advance address, decrement free
`ifndef RXDMA_REGS_SVH
`define RXDMA_REGS_SVH
`define RXDMA_OFS_SKIP 8'h00
`define RXDMA_OFS_HEAD 8'h04
`define RXDMA_OFS_FIRST 8'h08
`define RXDMA_OFS_ACTIVE 8'h0c
`define RXDMA_OFS_FILL 8'h10
`define RXDMA_OFS_LENS 8'h14
`define RXDMA_OFS_COMP 8'h18
`define RXDMA_DESC_LEN_OFS 32'h0000000c
`define RXDMA_COMP_MODE_BIT 0
`define RXDMA_RESET_WORD 32'h00000000
`endif

// >>> rtl/rxdma_pkg.sv
package rxdma_pkg;
  typedef enum logic [1:0] {ph_idle, ph_fetch, ph_data, ph_wb} rxdma_phase_t;
  typedef struct packed {
    logic [7:0] data;
    logic last;
  } rxdma_byte_t;
  typedef struct packed {
    logic [31:0] next_ptr;
    logic [31:0] buf_ptr;
    logic [15:0] buf_len;
  } rxdma_desc_t;
  typedef struct packed {
    rxdma_phase_t phase;
    logic [7:0] skip;
    logic [29:0] head;
    logic [29:0] first_ptr;
    logic in_packet;
    logic [29:0] active;
    logic [29:0] next_ptr;
    logic [31:0] fill_addr;
    logic [15:0] free;
    logic [15:0] total;
    logic first_seg;
    logic mem_valid;
    logic [31:0] mem_addr;
    logic [7:0] mem_data;
    logic desc_req;
    logic [31:0] desc_addr;
    logic wb_valid;
    logic [31:0] wb_addr;
    logic [31:0] wb_data;
    logic [31:0] rdata;
    logic eop;
  } rxdma_state_t;
  typedef struct packed {
    rxdma_byte_t [1:0] slot;
    logic wp;
    logic rp;
    logic [1:0] cnt;
    logic ready;
    logic valid;
  } rxdma_buf_state_t;
  typedef struct packed {
    logic [29:0] ptr;
    logic irq;
  } rxdma_cmp_state_t;
endpackage

// >>> rtl/rxdma_buf.sv
module rxdma_buf (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic in_valid,
  input rxdma_pkg::rxdma_byte_t in_data,
  output logic in_ready,
  output logic out_valid,
  output rxdma_pkg::rxdma_byte_t out_data,
  input wire logic out_ready
);
  rxdma_pkg::rxdma_buf_state_t st;
  rxdma_pkg::rxdma_buf_state_t next_st;
  logic push;
  logic pop;

  assign in_ready = st.ready;
  assign out_valid = st.valid;
  assign out_data = st.slot[st.rp];

  always_comb begin
    next_st = st;
    push = in_valid && st.ready;
    pop = st.valid && out_ready;
    if (push) begin
      next_st.slot[st.wp] = in_data;
      next_st.wp = ~st.wp;
    end
    if (pop) begin
      next_st.rp = ~st.rp;
    end
    if (push && !pop) begin
      next_st.cnt = st.cnt + 2'h1;
    end else if (pop && !push) begin
      next_st.cnt = st.cnt - 2'h1;
    end
    next_st.ready = (next_st.cnt != 2'h2);
    next_st.valid = (next_st.cnt != 2'h0);
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      st <= '0;
      st.ready <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  a_buf_count:
  assert property (@(posedge mclk) disable iff (!rst_n)
    st.cnt <= 2'h2 && st.ready == (st.cnt != 2'h2))
    else $error("buffer count or ready wrong");
endmodule

// >>> rtl/rxdma_cmp.sv
`include "rxdma_regs.svh"
module rxdma_cmp (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic wr,
  input wire logic [31:0] wdata,
  input wire logic eop,
  input wire logic [29:0] eop_ptr,
  output logic [29:0] ptr,
  output logic irq
);
  rxdma_pkg::rxdma_cmp_state_t st;
  rxdma_pkg::rxdma_cmp_state_t next_st;

  assign ptr = st.ptr;
  assign irq = st.irq;

  always_comb begin
    next_st = st;
    if (wr && wdata[`RXDMA_COMP_MODE_BIT]) begin
      next_st.ptr = wdata[31:2];
      next_st.irq = 1'b1;
    end else if (wr && wdata[31:2] == st.ptr) begin
      next_st.irq = 1'b0; // R10
    end
    // End of packet set wins over clear
    if (eop) begin
      next_st.ptr = eop_ptr;
      next_st.irq = 1'b1;
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  a_cmp_clear: // R10
  assert property (@(posedge mclk) disable iff (!rst_n)
    wr && !wdata[`RXDMA_COMP_MODE_BIT] && wdata[31:2] == st.ptr && !eop |=> !irq)
    else $error("compare match did not clear interrupt");
  a_cmp_keep: // R10
  assert property (@(posedge mclk) disable iff (!rst_n)
    wr && !wdata[`RXDMA_COMP_MODE_BIT] && wdata[31:2] != st.ptr && !eop
      |=> irq == $past(st.irq) && ptr == $past(st.ptr))
    else $error("compare mismatch changed state");
  a_eop_set:
  assert property (@(posedge mclk) disable iff (!rst_n)
    eop |=> irq && ptr == $past(eop_ptr))
    else $error("end of packet did not raise interrupt");
endmodule

// >>> rtl/rxdma_top.sv
`include "rxdma_regs.svh"
module rxdma_top (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  input wire logic ep_valid,
  input rxdma_pkg::rxdma_byte_t ep_data,
  output logic ep_ready,
  output logic desc_req,
  output logic [31:0] desc_addr,
  input wire logic desc_ack,
  input rxdma_pkg::rxdma_desc_t desc_in,
  output logic mem_valid,
  output logic [31:0] mem_addr,
  output logic [7:0] mem_data,
  input wire logic mem_ready,
  output logic wb_valid,
  output logic [31:0] wb_addr,
  output logic [31:0] wb_data,
  input wire logic wb_ready,
  output logic rx_irq
);
  rxdma_pkg::rxdma_state_t st;
  rxdma_pkg::rxdma_state_t next_st;
  logic bo_valid;
  rxdma_pkg::rxdma_byte_t bo;
  logic buf_take;
  logic comp_wr;
  logic [29:0] comp_ptr;
  logic [15:0] skip_wide;

  function automatic logic [29:0] ptr_of(input logic [31:0] a);
    ptr_of = a[31:2];
  endfunction

  function automatic logic [31:0] addr_of(input logic [29:0] p);
    addr_of = {p, 2'b00};
  endfunction

  rxdma_buf u_buf (
    .mclk(mclk),
    .rst_n(rst_n),
    .in_valid(ep_valid),
    .in_data(ep_data),
    .in_ready(ep_ready),
    .out_valid(bo_valid),
    .out_data(bo),
    .out_ready(buf_take)
  );

  assign comp_wr = reg_wr && reg_addr == `RXDMA_OFS_COMP;

  rxdma_cmp u_cmp (
    .mclk(mclk),
    .rst_n(rst_n),
    .wr(comp_wr),
    .wdata(reg_wdata),
    .eop(st.eop),
    .eop_ptr(st.active),
    .ptr(comp_ptr),
    .irq(rx_irq)
  );

  assign reg_rdata = st.rdata;
  assign desc_req = st.desc_req;
  assign desc_addr = st.desc_addr;
  assign mem_valid = st.mem_valid;
  assign mem_addr = st.mem_addr;
  assign mem_data = st.mem_data;
  assign wb_valid = st.wb_valid;
  assign wb_addr = st.wb_addr;
  assign wb_data = st.wb_data;
  assign skip_wide = {8'h00, st.skip};

  always_comb begin
    next_st = st;
    buf_take = 1'b0;
    next_st.eop = 1'b0;
    next_st.rdata = `RXDMA_RESET_WORD;
    if (mem_ready) begin
      next_st.mem_valid = 1'b0;
    end
    case (st.phase)
      rxdma_pkg::ph_idle: begin
        if (bo_valid && st.head != 30'h0) begin
          next_st.phase = rxdma_pkg::ph_fetch;
          next_st.in_packet = 1'b1; // R5
          next_st.first_ptr = st.head; // R4
          next_st.active = st.head; // R6
          next_st.first_seg = 1'b1;
          next_st.total = 16'h0000;
          next_st.desc_req = 1'b1;
          next_st.desc_addr = addr_of(st.head);
        end
      end
      rxdma_pkg::ph_fetch: begin
        if (desc_ack) begin
          next_st.desc_req = 1'b0;
          next_st.next_ptr = ptr_of(desc_in.next_ptr);
          next_st.head = ptr_of(desc_in.next_ptr); // R3
          next_st.first_seg = 1'b0;
          next_st.phase = rxdma_pkg::ph_data;
          if (st.first_seg) begin
            next_st.fill_addr = desc_in.buf_ptr + {24'h000000, st.skip}; // R1
            if (desc_in.buf_len > skip_wide) begin
              next_st.free = desc_in.buf_len - skip_wide; // R1
            end else begin
              next_st.free = 16'h0000;
            end
          end else begin
            next_st.fill_addr = desc_in.buf_ptr; // R7
            next_st.free = desc_in.buf_len; // R9
          end
        end
      end
      rxdma_pkg::ph_data: begin
        if (st.free == 16'h0000) begin
          next_st.active = st.next_ptr; // R11
          next_st.desc_req = 1'b1;
          next_st.desc_addr = addr_of(st.next_ptr);
          next_st.phase = rxdma_pkg::ph_fetch;
        end else if (bo_valid && (!st.mem_valid || mem_ready)) begin
          buf_take = 1'b1;
          next_st.mem_valid = 1'b1;
          next_st.mem_addr = st.fill_addr;
          next_st.mem_data = bo.data;
          next_st.fill_addr = st.fill_addr + 32'h00000001; // R11
          next_st.free = st.free - 16'h0001; // R9
          next_st.total = st.total + 16'h0001; // R8
          if (bo.last) begin
            next_st.phase = rxdma_pkg::ph_wb;
            next_st.wb_valid = 1'b1;
            next_st.wb_addr = addr_of(st.first_ptr) + `RXDMA_DESC_LEN_OFS; // R8
            next_st.wb_data = {16'h0000, st.total + 16'h0001}; // R8
          end
        end
      end
      rxdma_pkg::ph_wb: begin
        if (wb_ready) begin
          next_st.wb_valid = 1'b0;
          next_st.in_packet = 1'b0; // R5
          next_st.phase = rxdma_pkg::ph_idle;
          next_st.eop = 1'b1;
        end
      end
      default: begin
        next_st.phase = rxdma_pkg::ph_idle;
      end
    endcase
    // Skip count may change any time; head, first, active, fill and lengths only while idle
    if (reg_wr) begin
      if (reg_addr == `RXDMA_OFS_SKIP) begin
        next_st.skip = reg_wdata[7:0];
      end else if (st.phase == rxdma_pkg::ph_idle && next_st.phase == rxdma_pkg::ph_idle) begin
        if (reg_addr == `RXDMA_OFS_HEAD) begin
          next_st.head = ptr_of(reg_wdata);
        end else if (reg_addr == `RXDMA_OFS_FIRST) begin
          next_st.first_ptr = ptr_of(reg_wdata);
        end else if (reg_addr == `RXDMA_OFS_ACTIVE) begin
          next_st.active = ptr_of(reg_wdata);
        end else if (reg_addr == `RXDMA_OFS_FILL) begin
          next_st.fill_addr = reg_wdata;
        end else if (reg_addr == `RXDMA_OFS_LENS) begin
          next_st.total = reg_wdata[31:16];
          next_st.free = reg_wdata[15:0];
        end
      end
    end
    if (reg_rd) begin
      if (reg_addr == `RXDMA_OFS_SKIP) begin
        next_st.rdata = {24'h000000, st.skip};
      end else if (reg_addr == `RXDMA_OFS_HEAD) begin
        next_st.rdata = addr_of(st.head); // R3
      end else if (reg_addr == `RXDMA_OFS_FIRST) begin
        next_st.rdata = {st.first_ptr, 1'b0, st.in_packet}; // R4
      end else if (reg_addr == `RXDMA_OFS_ACTIVE) begin
        next_st.rdata = addr_of(st.active); // R6
      end else if (reg_addr == `RXDMA_OFS_FILL) begin
        next_st.rdata = st.fill_addr; // R7
      end else if (reg_addr == `RXDMA_OFS_LENS) begin
        next_st.rdata = {st.total, st.free}; // R9
      end else if (reg_addr == `RXDMA_OFS_COMP) begin
        next_st.rdata = addr_of(comp_ptr);
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  a_skip_start: // R1
  assert property (@(posedge mclk) disable iff (!rst_n)
    st.phase == rxdma_pkg::ph_fetch && desc_ack && st.first_seg && !reg_wr
      |=> st.fill_addr == $past(desc_in.buf_ptr) + {24'h000000, $past(st.skip)})
    else $error("skip count not applied at packet start");

  a_head_read: // R3
  assert property (@(posedge mclk) disable iff (!rst_n)
    reg_rd && reg_addr == `RXDMA_OFS_HEAD
      |=> reg_rdata[1:0] == 2'b00 && reg_rdata[31:2] == $past(st.head))
    else $error("head pointer read wrong");

  a_first_ptr: // R4
  assert property (@(posedge mclk) disable iff (!rst_n)
    st.phase == rxdma_pkg::ph_idle && bo_valid && st.head != 30'h0
      |=> st.first_ptr == $past(st.head) && st.desc_addr == {$past(st.head), 2'b00})
    else $error("first descriptor not latched");

  a_packet_flag: // R5
  assert property (@(posedge mclk) disable iff (!rst_n)
    st.in_packet == (st.phase != rxdma_pkg::ph_idle))
    else $error("packet flag disagrees with phase");

  a_active_fetch: // R6
  assert property (@(posedge mclk) disable iff (!rst_n)
    st.desc_req |-> st.desc_addr == {st.active, 2'b00})
    else $error("fetch address is not active descriptor");

  a_byte_step: // R7 R9 R11
  assert property (@(posedge mclk) disable iff (!rst_n)
    buf_take |=> st.mem_valid && st.mem_addr == $past(st.fill_addr)
      && st.fill_addr == $past(st.fill_addr) + 32'h00000001
      && st.free == $past(st.free) - 16'h0001)
    else $error("byte store did not step address and free count");

  a_len_write: // R8
  assert property (@(posedge mclk) disable iff (!rst_n)
    buf_take && bo.last |=> st.wb_valid
      && st.wb_data[15:0] == $past(st.total) + 16'h0001
      && st.wb_addr == {$past(st.first_ptr), 2'b00} + `RXDMA_DESC_LEN_OFS)
    else $error("packet length writeback wrong");

  a_chain_next: // R11
  assert property (@(posedge mclk) disable iff (!rst_n)
    st.phase == rxdma_pkg::ph_data && st.free == 16'h0000
      |=> st.phase == rxdma_pkg::ph_fetch && st.active == $past(st.next_ptr))
    else $error("empty buffer did not chain to next descriptor");

  a_skip_write: // R2
  assert property (@(posedge mclk) disable iff (!rst_n)
    reg_wr && reg_addr == `RXDMA_OFS_SKIP |=> {24'h000000, st.skip} == ($past(reg_wdata) & 32'h000000ff))
    else $error("skip count write lost");

  a_rdata_idle:
  assert property (@(posedge mclk) disable iff (!rst_n)
    !reg_rd |=> reg_rdata == `RXDMA_RESET_WORD)
    else $error("read data not zero outside read cycle");

  a_busy_hold: // R3
  assert property (@(posedge mclk) disable iff (!rst_n)
    reg_wr && reg_addr == `RXDMA_OFS_HEAD && st.phase == rxdma_pkg::ph_data
      |=> st.head == $past(st.head))
    else $error("head pointer written while busy");

  a_first_read: // R4 R5
  assert property (@(posedge mclk) disable iff (!rst_n)
    reg_rd && reg_addr == `RXDMA_OFS_FIRST
      |=> reg_rdata == {$past(st.first_ptr), 1'b0, $past(st.in_packet)})
    else $error("first descriptor word read wrong");

  a_active_read: // R6
  assert property (@(posedge mclk) disable iff (!rst_n)
    reg_rd && reg_addr == `RXDMA_OFS_ACTIVE
      |=> reg_rdata == {$past(st.active), 2'b00})
    else $error("active descriptor word read wrong");

  a_fill_read: // R7
  assert property (@(posedge mclk) disable iff (!rst_n)
    reg_rd && reg_addr == `RXDMA_OFS_FILL
      |=> reg_rdata == $past(st.fill_addr))
    else $error("fill address read wrong");

  a_lens_read: // R8 R9
  assert property (@(posedge mclk) disable iff (!rst_n)
    reg_rd && reg_addr == `RXDMA_OFS_LENS
      |=> reg_rdata == {$past(st.total), $past(st.free)})
    else $error("length word read wrong");

  a_later_buffer: // R7 R9
  assert property (@(posedge mclk) disable iff (!rst_n)
    st.phase == rxdma_pkg::ph_fetch && desc_ack && !st.first_seg
      |=> st.fill_addr == $past(desc_in.buf_ptr) && st.free == $past(desc_in.buf_len))
    else $error("later buffer not loaded from descriptor");

  a_head_follow: // R3
  assert property (@(posedge mclk) disable iff (!rst_n)
    st.phase == rxdma_pkg::ph_fetch && desc_ack
      |=> {st.head, 2'b00} == ($past(desc_in.next_ptr) & 32'hfffffffc))
    else $error("head pointer did not follow chain");

  a_total_step: // R8
  assert property (@(posedge mclk) disable iff (!rst_n)
    buf_take |=> st.total == $past(st.total) + 16'h0001)
    else $error("packet byte total did not count");

  a_wb_done: // R5
  assert property (@(posedge mclk) disable iff (!rst_n)
    st.phase == rxdma_pkg::ph_wb && wb_ready
      |=> st.phase == rxdma_pkg::ph_idle && !st.in_packet && st.eop && !st.wb_valid)
    else $error("writeback did not end packet");

  a_take_gate: // R11
  assert property (@(posedge mclk) disable iff (!rst_n)
    buf_take |-> bo_valid && st.free != 16'h0000 && st.phase == rxdma_pkg::ph_data)
    else $error("byte taken with no room");

  a_wait_hold: // R6
  assert property (@(posedge mclk) disable iff (!rst_n)
    st.desc_req && !desc_ack |=> st.desc_req && $stable(st.desc_addr))
    else $error("descriptor request dropped before answer");

  a_mem_hold: // R11
  assert property (@(posedge mclk) disable iff (!rst_n)
    st.mem_valid && !mem_ready
      |=> st.mem_valid && $stable(st.mem_addr) && $stable(st.mem_data))
    else $error("byte write changed before accepted");
endmodule

// >>> verification/rxdma_mem_model.sv
module rxdma_mem_model (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic slow,
  input wire logic desc_req,
  input wire logic [31:0] desc_addr,
  output logic desc_ack,
  output rxdma_pkg::rxdma_desc_t desc_in,
  input wire logic mem_valid,
  input wire logic [31:0] mem_addr,
  input wire logic [7:0] mem_data,
  output logic mem_ready,
  input wire logic wb_valid,
  input wire logic [31:0] wb_addr,
  input wire logic [31:0] wb_data,
  output logic wb_ready
);
  timeunit 1ns;
  timeprecision 1ns;
  rxdma_pkg::rxdma_desc_t tab [logic [31:0]];
  logic [31:0] wa [$];
  logic [7:0] wd [$];
  logic [31:0] wba;
  logic [31:0] wbd;
  int wait_c;

  // Descriptor fetch, byte and writeback sinks; stalls while slow
  always @(posedge mclk) begin
    desc_ack <= 1'b0;
    desc_in <= rst_n ? ~desc_in : '0;
    mem_ready <= rst_n && !slow;
    wb_ready <= rst_n && !slow;
    if (!rst_n) begin
      wait_c <= 0;
    end else if (wait_c < 0) begin
      wait_c <= wait_c + 1;
    end else if (desc_req) begin
      if (wait_c >= (slow ? 6 : 1)) begin
        desc_ack <= 1'b1;
        desc_in <= tab[desc_addr];
        wait_c <= -3;
      end else begin
        wait_c <= wait_c + 1;
      end
    end
    if (rst_n && mem_valid && mem_ready) begin
      wa.push_back(mem_addr);
      wd.push_back(mem_data);
    end
    if (rst_n && wb_valid && wb_ready) begin
      wba <= wb_addr;
      wbd <= wb_data;
    end
  end
endmodule

// >>> verification/tb.sv
`include "rxdma_regs.svh"
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic mclk, rst_n, reg_wr, reg_rd, ep_valid, slow, ep_ready, desc_req, desc_ack;
  logic mem_valid, mem_ready, wb_valid, wb_ready, rx_irq;
  logic [7:0] reg_addr, mem_data;
  logic [31:0] reg_wdata, reg_rdata, desc_addr, mem_addr, wb_addr, wb_data;
  rxdma_pkg::rxdma_byte_t ep_data;
  rxdma_pkg::rxdma_desc_t desc_in;
  int num_errors, compares;

  rxdma_top dut (.mclk, .rst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .ep_valid, .ep_data, .ep_ready, .desc_req, .desc_addr, .desc_ack, .desc_in,
    .mem_valid, .mem_addr, .mem_data, .mem_ready, .wb_valid, .wb_addr, .wb_data,
    .wb_ready, .rx_irq);
  rxdma_mem_model mem (.mclk, .rst_n, .slow, .desc_req, .desc_addr, .desc_ack, .desc_in,
    .mem_valid, .mem_addr, .mem_data, .mem_ready, .wb_valid, .wb_addr, .wb_data,
    .wb_ready);

  initial begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end

  task check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      num_errors++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask

  task rd(input logic [7:0] a, input logic [31:0] exp);
    @(posedge mclk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1 check(reg_rdata, exp);
  endtask

  task send(input int n);
    @(posedge mclk);
    for (int i = 0; i < n; i++) begin
      ep_valid <= 1'b1;
      ep_data <= {8'(8'ha0 + i), i == n - 1};
      do @(negedge mclk); while (ep_ready !== 1'b1);
      @(posedge mclk);
    end
    ep_valid <= 1'b0;
  endtask

  task irq_after(input logic [31:0] d, input logic exp);
    wr(`RXDMA_OFS_COMP, d);
    repeat (2) @(posedge mclk);
    #1 check(32'(rx_irq), 32'(exp));
  endtask

  task results;
    if (num_errors == 0 && compares > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge mclk);
    num_errors++;
    results;
  end

  initial begin
    rst_n = 1'b0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 32'h0;
    ep_valid = 1'b0;
    ep_data = '0;
    slow = 1'b1;
    num_errors = 0;
    compares = 0;
    repeat (10) @(posedge mclk);
    rst_n <= 1'b1;
    @(posedge mclk);
    #1 check(32'(ep_ready), 32'h1);
    for (int a = 0; a <= 8'h1c; a += 4) rd(a[7:0], 32'h0);
    wr(`RXDMA_OFS_SKIP, 32'h000001ff);
    rd(`RXDMA_OFS_SKIP, 32'h000000ff);
    wr(`RXDMA_OFS_HEAD, 32'hffffffff);
    rd(`RXDMA_OFS_HEAD, 32'hfffffffc);
    wr(`RXDMA_OFS_FIRST, 32'hffffffff);
    rd(`RXDMA_OFS_FIRST, 32'hfffffffc);
    wr(`RXDMA_OFS_ACTIVE, 32'hffffffff);
    rd(`RXDMA_OFS_ACTIVE, 32'hfffffffc);
    wr(`RXDMA_OFS_FILL, 32'h12345677);
    rd(`RXDMA_OFS_FILL, 32'h12345677);
    wr(`RXDMA_OFS_LENS, 32'hbeef1234);
    rd(`RXDMA_OFS_LENS, 32'hbeef1234);
    wr(8'h1c, 32'hffffffff);
    rd(8'h1c, 32'h0);
    for (int a = 4; a <= 8'h14; a += 4) wr(a[7:0], 32'h0);
    // Two chained buffers: 4 bytes then 8 bytes
    mem.tab[32'h100] = {32'h200, 32'h1000, 16'h0004};
    mem.tab[32'h200] = {32'h0, 32'h2000, 16'h0008};
    wr(`RXDMA_OFS_SKIP, 32'h2);
    fork
      send(5);
      begin
        repeat (12) @(posedge mclk);
        #1 check(32'(ep_ready), 32'h0);
        wr(`RXDMA_OFS_HEAD, 32'h100);
        repeat (20) @(posedge mclk);
        rd(`RXDMA_OFS_FIRST, 32'h101);
        rd(`RXDMA_OFS_ACTIVE, 32'h100);
        wr(`RXDMA_OFS_HEAD, 32'h300);
        rd(`RXDMA_OFS_HEAD, 32'h200);
        slow <= 1'b0;
      end
    join
    for (int i = 0; i < 300 && rx_irq !== 1'b1; i++) @(posedge mclk);
    #1 check(32'(rx_irq), 32'h1);
    check(32'(mem.wa.size()), 32'h5);
    for (int i = 0; i < 5 && i < mem.wa.size(); i++) begin
      check(mem.wa[i], i < 2 ? 32'h1002 + i : 32'h2000 + i - 2);
      check(32'(mem.wd[i]), 32'(8'ha0 + i));
    end
    check(mem.wba, 32'h10c);
    check(mem.wbd, 32'h5);
    rd(`RXDMA_OFS_HEAD, 32'h0);
    rd(`RXDMA_OFS_FIRST, 32'h100);
    rd(`RXDMA_OFS_ACTIVE, 32'h200);
    rd(`RXDMA_OFS_FILL, 32'h2003);
    rd(`RXDMA_OFS_LENS, 32'h00050005);
    rd(`RXDMA_OFS_COMP, 32'h200);
    irq_after(32'h100, 1'b1);
    irq_after(32'h200, 1'b0);
    irq_after(32'h41, 1'b1);
    rd(`RXDMA_OFS_COMP, 32'h40);
    results;
  end
endmodule
